//--- logic/dmi_core.sv
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: reading an indirect port location returns zero.
// RULE_02: writing an indirect port location changes no storage.
// RULE_03: port access acts on the location held in its pointer.
// RULE_04: port 0 with its pointer reaches sector 0 only.
// RULE_05: ports 1 and 2 reach any sector via high pointer byte.
// RULE_06: all five pointer bytes are readable and writable storage.
// RULE_07: extended direct address: upper part sector, low byte location.
// RULE_08: unassigned special locations read as zero.
// RULE_09: writing the pc low byte jumps to that location.
// RULE_10: that jump keeps the upper pc bits, staying in page.
// RULE_11: one dummy cycle follows a pc low byte write.
// RULE_12: the accumulator takes alu and shift results.
// RULE_13: no memory to memory move; data passes the accumulator.
// RULE_14: pointer pair concatenates sector and low byte, same cycle.
module dmi_core (
    input wire logic I_CLK,
    input wire logic I_RST,
    input dmi_pkg::dmi_req_t I_REQ,
    input dmi_pkg::dmi_apb_t I_APB,
    output dmi_pkg::dmi_rsp_t O_RSP,
    output logic [dmi_pkg::PC_W-1:0] O_PC,
    output logic [7:0] O_ACC,
    output logic O_DUMMY,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR
);
    import dmi_pkg::*;

    dmi_state_t st_r;
    dmi_state_t st_nxt;
    logic [7:0] eff_sect;
    logic [7:0] eff_addr;
    logic eff_port;
    logic gp_hit;
    logic [GP_IDX_W-1:0] gp_idx;
    logic take;
    logic [7:0] rd_val;
    logic [7:0] wr_data;
    logic sfr_known;
    logic jump;
    logic apb_page_wr;
    logic [GP_IDX_W-1:0] ext_idx;
    logic [GP_IDX_W-1:0] p1_idx;

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    dmi_addr_resolve u_resolve (
        .i_ext(I_REQ.ext),
        .i_sect(I_REQ.sect),
        .i_addr(I_REQ.addr),
        .i_mp0(st_r.mp0),
        .i_pointer1_low(st_r.pointer1_low),
        .i_pointer1_sector(st_r.pointer1_sector),
        .i_pointer2_low(st_r.pointer2_low),
        .i_pointer2_sector(st_r.pointer2_sector),
        .o_sect(eff_sect),
        .o_addr(eff_addr),
        .o_port(eff_port)
    );

    // general ram sits in the upper half of each implemented sector
    assign gp_hit = !eff_port && (eff_sect < SECT_CNT) &&
        (eff_addr >= GP_BASE);
    assign gp_idx = {eff_sect[SECT_W-1:0], eff_addr[6:0]};
    // helper indices, only read by the checks below
    assign ext_idx = {I_REQ.sect[SECT_W-1:0], I_REQ.addr[6:0]};
    assign p1_idx = {st_r.pointer1_sector[SECT_W-1:0], st_r.pointer1_low[6:0]};
    assign apb_page_wr = I_APB.psel && I_APB.penable && st_r.pready &&
        I_APB.pwrite && (I_APB.paddr == APB_PAGE);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // requests during the dummy cycle are dropped: the core must hold off
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.dummy = 1'b0;
        st_nxt.pready = 1'b0;
        take = (I_REQ.op != OP_NONE) && !st_r.dummy;
        rd_val = BYTE_ZERO;
        sfr_known = 1'b0;
        jump = 1'b0;
        // only the accumulator or the core's own result feeds a write
        wr_data = (I_REQ.op == OP_STA) ? st_r.acc : I_REQ.wdata; // RULE_13
        // read mux; ports and unused holes give zero
        if (eff_port) begin
            rd_val = BYTE_ZERO; // RULE_01
        end else if (gp_hit) begin
            rd_val = st_r.gp[gp_idx]; // RULE_03
        end else if (eff_sect == BYTE_ZERO) begin
            sfr_known = 1'b1;
            case (eff_addr)
                ADR_MP0: rd_val = st_r.mp0; // RULE_06
                ADR_POINTER1_LOW: rd_val = st_r.pointer1_low;
                ADR_POINTER1_SECTOR: rd_val = st_r.pointer1_sector;
                ADR_POINTER2_LOW: rd_val = st_r.pointer2_low;
                ADR_POINTER2_SECTOR: rd_val = st_r.pointer2_sector;
                ADR_ACC: rd_val = st_r.acc;
                ADR_PCL: rd_val = st_r.pc[7:0];
                default: begin
                    sfr_known = 1'b0;
                    rd_val = BYTE_ZERO; // RULE_08
                end
            endcase
        end
        // operation
        if (take) begin
            case (I_REQ.op)
                OP_RD: begin
                    st_nxt.rvalid = 1'b1;
                    st_nxt.rdata = rd_val;
                end
                OP_LDA: begin
                    st_nxt.acc = rd_val; // RULE_13
                end
                OP_ALU: begin
                    st_nxt.acc = I_REQ.wdata; // RULE_12
                end
                OP_WR, OP_STA: begin
                    if (eff_port) begin
                        st_nxt.acc = st_r.acc; // RULE_02
                    end else if (gp_hit) begin
                        st_nxt.gp[gp_idx] = wr_data; // RULE_03 RULE_07
                    end else if (eff_sect == BYTE_ZERO) begin
                        case (eff_addr)
                            ADR_MP0: st_nxt.mp0 = wr_data; // RULE_06
                            ADR_POINTER1_LOW: st_nxt.pointer1_low = wr_data;
                            ADR_POINTER1_SECTOR: st_nxt.pointer1_sector = wr_data;
                            ADR_POINTER2_LOW: st_nxt.pointer2_low = wr_data;
                            ADR_POINTER2_SECTOR: st_nxt.pointer2_sector = wr_data;
                            ADR_ACC: st_nxt.acc = wr_data;
                            ADR_PCL: begin
                                // upper bits kept: jump stays in page
                                st_nxt.pc = {st_r.pc[PC_W-1:8],
                                    wr_data}; // RULE_09 RULE_10
                                st_nxt.dummy = 1'b1; // RULE_11
                                jump = 1'b1;
                            end
                            default: begin
                                st_nxt.acc = st_r.acc;
                            end
                        endcase
                    end
                end
                default: begin
                    st_nxt.rvalid = 1'b0;
                end
            endcase
        end
        // sequential fetch; frozen through the dummy cycle
        if (I_REQ.step && !st_r.dummy && !jump) begin
            st_nxt.pc = st_r.pc + PC_ONE; // RULE_11
        end
        // apb setup: answer registered so pready rises in access phase
        if (I_APB.psel && !I_APB.penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata = 32'h0000_0000;
            case (I_APB.paddr)
                APB_PC_STAT: begin
                    st_nxt.prdata[PC_W-1:0] = st_r.pc;
                    st_nxt.prdata[DUMMY_BIT] = st_r.dummy;
                end
                APB_ACC_STAT: st_nxt.prdata[7:0] = st_r.acc;
                APB_PAGE: st_nxt.prdata[PAGE_W-1:0] = st_r.page;
                APB_PTR_STAT: begin
                    st_nxt.prdata = {st_r.pointer2_low, st_r.pointer1_sector, st_r.pointer1_low,
                        st_r.mp0};
                end
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
        // software restart of the program counter at a page start
        if (apb_page_wr) begin
            st_nxt.page = I_APB.pwdata[PAGE_W-1:0];
            st_nxt.pc = {I_APB.pwdata[PAGE_W-1:0], BYTE_ZERO};
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_r <= DMI_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign O_RSP = {st_r.rvalid, st_r.rdata};
    assign O_PC = st_r.pc;
    assign O_ACC = st_r.acc;
    assign O_DUMMY = st_r.dummy;
    assign O_PRDATA = st_r.prdata;
    assign O_PREADY = st_r.pready;
    assign O_PSLVERR = st_r.pslverr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_port_read_zero: assert property ( // RULE_01
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_RD) && eff_port
        |=> O_RSP.valid && (O_RSP.data == 8'h00))
        else $error("port read did not return zero");

    a_port_write_none: assert property ( // RULE_02
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && eff_port
        |=> $stable(st_r.gp) && $stable(st_r.mp0) &&
            $stable(st_r.pointer1_low) && $stable(st_r.acc) && !O_DUMMY)
        else $error("port write changed storage");

    a_port1_target: assert property ( // RULE_03
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && !I_REQ.ext &&
        (I_REQ.addr == ADR_PORT1) && (st_r.pointer1_sector < SECT_CNT) &&
        (st_r.pointer1_low >= GP_BASE)
        |=> st_r.gp[$past(p1_idx)] == $past(I_REQ.wdata))
        else $error("port 1 write missed its pointer target");

    a_port0_sector: assert property ( // RULE_04
        @(posedge I_CLK) disable iff (I_RST)
        !I_REQ.ext && (I_REQ.addr == ADR_PORT0) |-> eff_sect == 8'h00)
        else $error("port 0 left sector 0");

    a_port2_sector: assert property ( // RULE_05
        @(posedge I_CLK) disable iff (I_RST)
        !I_REQ.ext && (I_REQ.addr == ADR_PORT2)
        |-> (eff_sect == st_r.pointer2_sector) && (eff_addr == st_r.pointer2_low))
        else $error("port 2 address not formed from its pointer pair");

    a_ptr_store: assert property ( // RULE_06
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && !I_REQ.ext &&
        (I_REQ.addr == ADR_POINTER2_SECTOR)
        |=> (st_r.pointer2_sector == $past(I_REQ.wdata)) ##1 (st_r.pointer2_sector != 8'h00 ||
            $past(st_r.pointer2_sector) == 8'h00 || take))
        else $error("pointer byte not stored");

    a_ext_decode: assert property ( // RULE_07
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && I_REQ.ext &&
        (I_REQ.sect < SECT_CNT) && (I_REQ.addr >= GP_BASE)
        |=> st_r.gp[$past(ext_idx)] == $past(I_REQ.wdata))
        else $error("extended write went to the wrong location");

    a_unused_zero: assert property ( // RULE_08
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_RD) && !eff_port && !gp_hit && !sfr_known
        |=> O_RSP.data == 8'h00)
        else $error("unused location read non-zero");

    a_pcl_jump: assert property ( // RULE_09 RULE_10
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && !I_REQ.ext &&
        (I_REQ.addr == ADR_PCL) && !apb_page_wr
        |=> O_PC == {$past(O_PC[PC_W-1:8]), $past(I_REQ.wdata)})
        else $error("pc low write did not jump within the page");

    a_dummy_slot: assert property ( // RULE_11
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_WR) && !I_REQ.ext &&
        (I_REQ.addr == ADR_PCL) && !apb_page_wr
        |=> O_DUMMY ##1 !O_DUMMY && $stable(O_PC))
        else $error("dummy cycle missing after pc low write");

    a_acc_alu: assert property ( // RULE_12
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_ALU) |=> O_ACC == $past(I_REQ.wdata))
        else $error("alu result not in accumulator");

    a_sta_source: assert property ( // RULE_13
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_STA) && I_REQ.ext &&
        (I_REQ.sect < SECT_CNT) && (I_REQ.addr >= GP_BASE)
        |=> st_r.gp[$past(ext_idx)] == $past(st_r.acc))
        else $error("store did not take accumulator data");

    // port 0 reads the sector 0 byte even when sector 1 holds data there
    a_port0_read: assert property ( // RULE_04
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_RD) && !I_REQ.ext &&
        (I_REQ.addr == ADR_PORT0) && (st_r.mp0 >= GP_BASE)
        |=> O_RSP.data == $past(st_r.gp[{1'b0, st_r.mp0[6:0]}]))
        else $error("port 0 read left sector 0");

    a_lda_load: assert property ( // RULE_13
        @(posedge I_CLK) disable iff (I_RST)
        take && (I_REQ.op == OP_LDA) && gp_hit
        |=> O_ACC == $past(st_r.gp[gp_idx]))
        else $error("load did not bring the memory byte");

    a_apb_ready: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_APB.psel && !I_APB.penable && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
        else $error("apb ready not a single access cycle");

endmodule

//--- inc/dmi_pkg.sv
package dmi_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PC_W = 13;
    localparam int PAGE_W = PC_W - 8;
    localparam int SECT_W = 1;
    localparam int GP_IDX_W = 8;
    localparam int GP_DEPTH = 256;
    localparam logic [7:0] SECT_CNT = 8'h02;
    localparam logic [7:0] GP_BASE = 8'h80;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

    // ------------------------------------------------------------
    // sector 0 special locations
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_PORT0 = 8'h00;
    localparam logic [7:0] ADR_MP0 = 8'h01;
    localparam logic [7:0] ADR_PORT1 = 8'h02;
    localparam logic [7:0] ADR_POINTER1_LOW = 8'h03;
    localparam logic [7:0] ADR_POINTER1_SECTOR = 8'h04;
    localparam logic [7:0] ADR_ACC = 8'h05;
    localparam logic [7:0] ADR_PCL = 8'h06;
    localparam logic [7:0] ADR_PORT2 = 8'h07;
    localparam logic [7:0] ADR_POINTER2_LOW = 8'h08;
    localparam logic [7:0] ADR_POINTER2_SECTOR = 8'h09;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] APB_PC_STAT = 8'h00;
    localparam logic [7:0] APB_ACC_STAT = 8'h04;
    localparam logic [7:0] APB_PAGE = 8'h08;
    localparam logic [7:0] APB_PTR_STAT = 8'h0C;
    localparam int DUMMY_BIT = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_RD,
        OP_WR,
        OP_LDA,
        OP_STA,
        OP_ALU
    } dmi_op_t;

    typedef struct packed {
        dmi_op_t op;
        logic ext;
        logic [7:0] sect;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic step;
    } dmi_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dmi_rsp_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dmi_apb_t;

    typedef struct packed {
        logic [GP_DEPTH-1:0][7:0] gp;
        logic [7:0] mp0;
        logic [7:0] pointer1_low;
        logic [7:0] pointer1_sector;
        logic [7:0] pointer2_low;
        logic [7:0] pointer2_sector;
        logic [7:0] acc;
        logic [PC_W-1:0] pc;
        logic [PAGE_W-1:0] page;
        logic dummy;
        logic rvalid;
        logic [7:0] rdata;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dmi_state_t;

    localparam dmi_state_t DMI_RST = '0;

endpackage

//--- logic/dmi_addr_resolve.sv
`timescale 1ns/1ps
module dmi_addr_resolve (
    input wire logic i_ext,
    input wire logic [7:0] i_sect,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_mp0,
    input wire logic [7:0] i_pointer1_low,
    input wire logic [7:0] i_pointer1_sector,
    input wire logic [7:0] i_pointer2_low,
    input wire logic [7:0] i_pointer2_sector,
    output logic [7:0] o_sect,
    output logic [7:0] o_addr,
    output logic o_port
);
    import dmi_pkg::*;

    logic [7:0] dir_sect;

    // ------------------------------------------------------------
    // effective address
    // ------------------------------------------------------------
    // plain direct access lives in sector 0; extended carries the sector
    always_comb begin
        dir_sect = i_ext ? i_sect : BYTE_ZERO; // RULE_07
        o_sect = dir_sect;
        o_addr = i_addr;
        if (dir_sect == BYTE_ZERO) begin
            case (i_addr)
                ADR_PORT0: begin
                    o_sect = BYTE_ZERO; // RULE_04
                    o_addr = i_mp0;
                end
                ADR_PORT1: begin
                    o_sect = i_pointer1_sector; // RULE_05 RULE_14
                    o_addr = i_pointer1_low;
                end
                ADR_PORT2: begin
                    o_sect = i_pointer2_sector; // RULE_05 RULE_14
                    o_addr = i_pointer2_low;
                end
                default: begin
                    o_sect = dir_sect;
                end
            endcase
        end
        // a pointer aimed at a port lands on nothing: no double hop
        o_port = (o_sect == BYTE_ZERO) && ((o_addr == ADR_PORT0) ||
            (o_addr == ADR_PORT1) || (o_addr == ADR_PORT2));
    end

endmodule

//--- testbench/dmi_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// instruction side of the core, as seen by the data memory
// ------------------------------------------------------------
module dmi_core_model
    import dmi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_dummy,
    output dmi_pkg::dmi_req_t o_req
);
    // one request a cycle; moves between locations are only ever
    // issued as a load into and a store out of the accumulator
    dmi_req_t req_r = '0;
    logic [7:0] lost_r = 8'h00;

    assign o_req = req_r;

    // requests seen while the dummy cycle stands are dropped by the
    // design; counting them lets the bench prove that nothing leaked
    always @(posedge i_clk) begin
        if (i_dummy && (req_r.op != OP_NONE)) begin
            lost_r <= lost_r + 8'h01;
        end
    end

    // drive just after a rising edge, so the request is taken at the
    // following edge; return at the falling edge, where the answer to
    // the previous request has settled
    task automatic step(input dmi_req_t r);
        @(posedge i_clk);
        req_r <= r;
        @(negedge i_clk);
    endtask
endmodule

//--- testbench/data_memory_indirect_addressing_test.sv
`timescale 1ns/1ps
module data_memory_indirect_addressing_test;
    import dmi_pkg::*;

    typedef struct packed {
        dmi_req_t req;
        logic [1:0] kind;
        logic [7:0] exp;
    } dmi_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    dmi_req_t req;
    dmi_apb_t apb_r = '0;
    dmi_rsp_t rsp;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic dummy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_errors = 0;
    int cmp_count = 0;
    dmi_row_t rows[$];
    dmi_req_t idle = '0;
    dmi_req_t stp;
    logic [31:0] rd;
    logic er;

    // ------------------------------------------------------------
    // clock, design and core model
    // ------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end

    dmi_core i_dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_APB(apb_r),
        .O_RSP(rsp), .O_PC(pc), .O_ACC(acc), .O_DUMMY(dummy),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));

    dmi_core_model i_core (.i_clk(clk), .i_dummy(dummy), .o_req(req));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // sector 00 means a plain direct access, any other an extended one
    function automatic dmi_row_t mk(dmi_op_t op, logic [7:0] s,
        logic [7:0] a, logic [7:0] d, logic [1:0] k, logic [7:0] e);
        return '{'{op, (s != 8'h00), s, a, d, 1'b0}, k, e};
    endfunction

    // request only, for the hand-written tests
    function automatic dmi_req_t mq(dmi_op_t op, logic [7:0] s,
        logic [7:0] a, logic [7:0] d);
        dmi_row_t t;
        t = mk(op, s, a, d, 2'h0, 8'h00);
        return t.req;
    endfunction

    // apb master: hold the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r, output logic e);
        @(posedge clk);
        apb_r <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk);
        apb_r.penable <= 1'b1;
        // no limit of its own: a wait that never ends meets the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apb_r <= '0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hang is cut short well after the fewer than one hundred cycles needed
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        $display("[FAIL] watchdog expected end seen hang");
        end_sim();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        chk("pc in reset", 32'(pc), 32'h0);
        chk("acc in reset", 32'(acc), 32'h0);
        rst <= 1'b0;
        $display("test reset done");
        rows.push_back(mk(OP_WR, 8'h00, ADR_MP0, 8'h85, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h00, ADR_MP0, 8'h00, 2'h1, 8'h85));
        rows.push_back(mk(OP_WR, 8'h00, ADR_PORT0, 8'h3C, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h00, ADR_PORT0, 8'h00, 2'h1, 8'h3C));
        rows.push_back(mk(OP_RD, 8'h00, 8'h85, 8'h00, 2'h1, 8'h3C));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER1_SECTOR, 8'h01, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER1_LOW, 8'h85, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_PORT1, 8'hA5, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h01, 8'h85, 8'h00, 2'h1, 8'hA5));
        rows.push_back(mk(OP_RD, 8'h00, ADR_PORT1, 8'h00, 2'h1, 8'hA5));
        rows.push_back(mk(OP_RD, 8'h00, 8'h85, 8'h00, 2'h1, 8'h3C));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER2_SECTOR, 8'h01, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER2_LOW, 8'hF0, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_PORT2, 8'h77, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h01, 8'hF0, 8'h00, 2'h1, 8'h77));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER2_SECTOR, 8'h00, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_POINTER2_LOW, ADR_PORT2, 2'h0, 8'h00));
        rows.push_back(mk(OP_WR, 8'h00, ADR_PORT2, 8'h99, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h00, ADR_PORT2, 8'h00, 2'h1, 8'h00));
        rows.push_back(mk(OP_RD, 8'h00, ADR_POINTER2_LOW, 8'h00, 2'h1, 8'h07));
        rows.push_back(mk(OP_WR, 8'h00, 8'h0A, 8'hFF, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h00, 8'h0A, 8'h00, 2'h1, 8'h00));
        rows.push_back(mk(OP_WR, 8'h02, 8'h85, 8'h11, 2'h0, 8'h00));
        rows.push_back(mk(OP_RD, 8'h02, 8'h85, 8'h00, 2'h1, 8'h00));
        rows.push_back(mk(OP_ALU, 8'h00, 8'h00, 8'h5E, 2'h2, 8'h5E));
        rows.push_back(mk(OP_STA, 8'h01, 8'h90, 8'h00, 2'h0, 8'h00));
        rows.push_back(mk(OP_ALU, 8'h00, 8'h00, 8'h00, 2'h2, 8'h00));
        rows.push_back(mk(OP_LDA, 8'h01, 8'h90, 8'h00, 2'h2, 8'h5E));
        rows.push_back(mk(OP_RD, 8'h00, ADR_ACC, 8'h00, 2'h1, 8'h5E));
        // writes run back to back, each check waits one idle cycle
        foreach (rows[i]) begin
            i_core.step(rows[i].req);
            if (rows[i].kind != 2'h0) begin
                i_core.step(idle);
                if (rows[i].kind == 2'h1) begin
                    chk("read valid", 32'(rsp.valid), 32'h1);
                    chk($sformatf("row %0d", i), 32'(rsp.data),
                        32'(rows[i].exp));
                end else begin
                    chk("acc", 32'(acc), 32'(rows[i].exp));
                end
            end
        end
        $display("test table done");
        // page 09 gives a nonzero upper pc to be kept by the jump
        apb(1'b1, APB_PAGE, 32'h9, rd, er);
        stp = mq(OP_RD, 8'h00, ADR_ACC, 8'h00);
        stp.step = 1'b1;
        i_core.step(mq(OP_WR, 8'h00, ADR_PCL, 8'h5A));
        i_core.step(stp);
        chk("pc after jump", 32'(pc), 32'h095A);
        chk("dummy set", 32'(dummy), 32'h1);
        i_core.step(idle);
        chk("pc in dummy", 32'(pc), 32'h095A);
        chk("dummy gone", 32'(dummy), 32'h0);
        chk("no read in dummy", 32'(rsp.valid), 32'h0);
        i_core.step(stp);
        i_core.step(idle);
        chk("pc stepped", 32'(pc), 32'h095B);
        chk("acc read", 32'(rsp.data), 32'h5E);
        chk("lost in dummy", 32'(i_core.lost_r), 32'h1);
        $display("test jump done");
        apb(1'b0, APB_PC_STAT, 32'h0, rd, er);
        chk("pc stat", rd, 32'h095B);
        apb(1'b0, APB_PTR_STAT, 32'h0, rd, er);
        chk("pointers", rd, 32'h07018585);
        apb(1'b0, APB_ACC_STAT, 32'h0, rd, er);
        chk("acc stat", rd, 32'h5E);
        chk("acc stat err", 32'(er), 32'h0);
        apb(1'b1, 8'h10, 32'hFF, rd, er);
        chk("unmapped write err", 32'(er), 32'h1);
        apb(1'b0, 8'h10, 32'h0, rd, er);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped read err", 32'(er), 32'h1);
        $display("test apb done");
        // extended write, then the same byte through the port 1 pair
        i_core.step(mq(OP_WR, 8'h01, 8'hC3, 8'h6B));
        i_core.step(mq(OP_WR, 8'h00, ADR_POINTER1_LOW, 8'hC3));
        i_core.step(mq(OP_RD, 8'h00, ADR_PORT1, 8'h00));
        i_core.step(idle);
        chk("ext via port 1", 32'(rsp.data), 32'h6B);
        i_core.step(mq(OP_RD, 8'h00, 8'hC3, 8'h00));
        i_core.step(idle);
        chk("sector 0 apart", 32'(rsp.data), 32'h00);
        $display("test extended done");
        // a second reset in mid-run clears pointers and pc
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("pc after reset", 32'(pc), 32'h0);
        chk("acc after reset", 32'(acc), 32'h0);
        i_core.step(mq(OP_RD, 8'h00, ADR_MP0, 8'h00));
        i_core.step(idle);
        chk("pointer after reset", 32'(rsp.data), 32'h0);
        $display("test second reset done");
        end_sim();
    end
endmodule
